// File: fsrl_cmd_dec.sv
`timescale 1ns/1ps
`default_nettype none
module fsrl_cmd_dec import fsrl_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic clr,
	input wire logic wr,
	input wire logic [7:0] din,
	output logic c_prog,
	output logic c_chip,
	output logic c_sect,
	output logic c_auto,
	output logic c_reset,
	output logic c_susp,
	output logic c_one_sect
);
	fsrl_seq_t sq_q, sq_d;

	always_comb begin
		sq_d = sq_q;
		c_prog = 1'b0;
		c_chip = 1'b0;
		c_sect = 1'b0;
		c_auto = 1'b0;
		c_reset = 1'b0;
		c_susp = 1'b0;
		c_one_sect = 1'b0;
		if (wr) begin
			if (din == CMD_RESET) begin
				c_reset = 1'b1;
				sq_d = SQ_IDLE;
			end else begin
				sq_d = SQ_IDLE;
				case (sq_q)
					SQ_IDLE: begin
						if (din == CMD_UNLK1) sq_d = SQ_U1;
						c_susp = (din == CMD_SUSP);
						c_one_sect = (din == CMD_SECT);
					end
					SQ_U1: if (din == CMD_UNLK2) sq_d = SQ_U2;
					SQ_U2: begin
						if (din == CMD_PROG) sq_d = SQ_PROG;
						if (din == CMD_ERASE) sq_d = SQ_E1;
						c_auto = (din == CMD_AUTO);
					end
					SQ_PROG: c_prog = 1'b1;
					SQ_E1: if (din == CMD_UNLK1) sq_d = SQ_E2;
					SQ_E2: if (din == CMD_UNLK2) sq_d = SQ_E3;
					SQ_E3: begin
						c_chip = (din == CMD_CHIP);
						c_sect = (din == CMD_SECT);
					end
					default: sq_d = SQ_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sq_q <= SQ_IDLE;
		end else if (clr) begin
			sq_q <= SQ_IDLE;
		end else begin
			sq_q <= sq_d;
		end
	end
endmodule
`default_nettype wire

// File: fsrl_cnt.sv
`timescale 1ns/1ps
`default_nettype none
module fsrl_cnt import fsrl_pkg::*; #(
	parameter int W = CNT_W
)(
	input wire logic clk,
	input wire logic rstn,
	input wire logic clr,
	input wire logic en,
	input wire logic [W-1:0] lim,
	output logic hit
);
	logic [W-1:0] cnt_q;

	// Saturates at the limit so hit stays up until cleared
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
		end else if (clr) begin
			cnt_q <= '0;
		end else if (en && cnt_q != lim) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign hit = (cnt_q == lim);
endmodule
`default_nettype wire

// File: fsrl_host.sv
`timescale 1ns/1ps
`default_nettype none
module fsrl_host import fsrl_pkg::*; (
	input wire logic clk,
	output logic we_n,
	output logic [7:0] din,
	output logic rd_strobe
);
	initial begin
		we_n = 1'b1;
		din = 8'h00;
		rd_strobe = 1'b0;
	end
	// Byte held into the first high cycle, where it is taken
	task automatic wr(input logic [7:0] b);
		@(negedge clk);
		we_n = 1'b0;
		din = b;
		@(negedge clk);
		we_n = 1'b1;
		@(negedge clk);
		// No longer held: flip it so a late sample shows
		din = ~b;
	endtask
	task automatic rd();
		@(negedge clk);
		rd_strobe = 1'b1;
		@(negedge clk);
		rd_strobe = 1'b0;
	endtask
endmodule
`default_nettype wire

// File: fsrl_pkg.sv
`default_nettype none
package fsrl_pkg;

	// Status bit positions on the data outputs
	localparam int DQ_POLL = 7;
	localparam int DQ_TGL1 = 6;
	localparam int DQ_LIMIT = 5;
	localparam int DQ_TIMER = 3;
	localparam int DQ_TGL2 = 2;

	// Command bytes, plain defaults
	localparam logic [7:0] CMD_UNLK1 = 8'haa;
	localparam logic [7:0] CMD_UNLK2 = 8'h55;
	localparam logic [7:0] CMD_PROG = 8'ha0;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_CHIP = 8'h10;
	localparam logic [7:0] CMD_SECT = 8'h30;
	localparam logic [7:0] CMD_AUTO = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_SUSP = 8'hb0;

	// Timebase
	localparam int CLK_NS = 10;
	localparam int ERASE_WIN_US = 50;
	localparam int ERASE_WIN_CYC_D = ERASE_WIN_US * 1000 / CLK_NS;
	localparam int READY_BUSY_NS = 20000;
	localparam int READY_BUSY_CYC_D = (READY_BUSY_NS + CLK_NS - 1) / CLK_NS;
	localparam int READY_IDLE_NS = 500;
	localparam int READY_IDLE_CYC_D = (READY_IDLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int TRR_NS = 250;
	localparam int TRR_CYC = TRR_NS / CLK_NS;
	// Margin for the write edge detect and state entry
	localparam int TRR_LIM = TRR_CYC - 4;
	localparam int PULSE_LIMIT_D = 1024;
	localparam int CNT_W = 16;

	typedef enum logic [3:0] {
		ST_READ,
		ST_AUTOSEL,
		ST_PROG,
		ST_WIN,
		ST_ERASE,
		ST_SUSPEND,
		ST_SPROG,
		ST_FAIL,
		ST_RCMD,
		ST_HWRST
	} fsrl_state_t;

	typedef enum logic [2:0] {
		SQ_IDLE,
		SQ_U1,
		SQ_U2,
		SQ_PROG,
		SQ_E1,
		SQ_E2,
		SQ_E3
	} fsrl_seq_t;

endpackage
`default_nettype wire

// File: fsrl_top.sv
`timescale 1ns/1ps
`default_nettype none
module fsrl_top import fsrl_pkg::*; #(
	parameter int unsigned ERASE_WIN_CYC = ERASE_WIN_CYC_D,
	parameter int unsigned READY_BUSY_CYC = READY_BUSY_CYC_D,
	parameter int unsigned READY_IDLE_CYC = READY_IDLE_CYC_D,
	parameter int unsigned PULSE_LIMIT = PULSE_LIMIT_D
)(
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic HW_RESET_N,
	input wire logic WE_N,
	input wire logic [7:0] DIN,
	input wire logic RD_STROBE,
	input wire logic RD_IN_ERASE,
	input wire logic [7:0] ARRAY_DATA,
	input wire logic PULSE_TICK,
	input wire logic OP_DONE,
	output logic [7:0] DQ_OUT,
	output logic READY_BUSY_N_N_O,
	output logic READY_BUSY_N_N_OE,
	output logic OP_START_PROG,
	output logic OP_START_ERASE,
	output logic OP_CHIP,
	output logic OP_SECT_ADD,
	output logic OP_SUSPEND,
	output logic OP_RESUME,
	output logic OP_ABORT,
	output logic MODE_AUTOSEL
);
	localparam logic [CNT_W-1:0] WIN_LIM = CNT_W'(ERASE_WIN_CYC);
	localparam logic [CNT_W-1:0] RB_LIM = CNT_W'(READY_BUSY_CYC);
	localparam logic [CNT_W-1:0] RI_LIM = CNT_W'(READY_IDLE_CYC);
	localparam logic [CNT_W-1:0] PL_LIM = CNT_W'(PULSE_LIMIT);
	localparam logic [CNT_W-1:0] RC_LIM = CNT_W'(TRR_LIM);
	fsrl_state_t st_q, st_d;
	logic we_q;
	logic wr;
	logic c_prog, c_chip, c_sect, c_auto, c_reset, c_susp, c_one_sect;
	logic pl_hit, win_hit, rr_hit, rc_hit;
	logic hw_start, running, pl_en;
	logic start_prog, start_erase, chip, sect_add, susp, resume, abort;
	logic hr_busy_q, fail_susp_q, fail_erase_q, rcmd_susp_q, prog_bit_q;
	logic t1_q, t2_q;
	logic [7:0] dq_d;
	logic rb_oe_d;
	logic [CNT_W-1:0] rr_lim;
	// Write strobe rising edge; the command byte is taken on it
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			we_q <= 1'b1;
		end else begin
			we_q <= WE_N;
		end
	end
	assign wr = WE_N & ~we_q;
	fsrl_cmd_dec u_dec (
		.clk(SYS_CLK),
		.rstn(RSTN),
		.clr(st_q == ST_HWRST),
		.wr(wr),
		.din(DIN),
		.c_prog(c_prog),
		.c_chip(c_chip),
		.c_sect(c_sect),
		.c_auto(c_auto),
		.c_reset(c_reset),
		.c_susp(c_susp),
		.c_one_sect(c_one_sect)
	);
	assign running = (st_q == ST_PROG) || (st_q == ST_ERASE) ||
		(st_q == ST_SPROG);
	assign pl_en = running && PULSE_TICK;
	assign hw_start = !HW_RESET_N && (st_q != ST_HWRST);
	assign rr_lim = hr_busy_q ? RB_LIM : RI_LIM;
	// Pulse count limit; a program of 1 over 0 never completes, so it
	// runs into this limit as well
	fsrl_cnt u_pulse (
		.clk(SYS_CLK),
		.rstn(RSTN),
		.clr(start_prog | start_erase),
		.en(pl_en),
		.lim(PL_LIM),
		.hit(pl_hit)
	);

	// Sector erase acceptance window, restarted by each added sector
	fsrl_cnt u_win (
		.clk(SYS_CLK),
		.rstn(RSTN),
		.clr(sect_add),
		.en(st_q == ST_WIN),
		.lim(WIN_LIM),
		.hit(win_hit)
	);
	fsrl_cnt u_recover (
		.clk(SYS_CLK),
		.rstn(RSTN),
		.clr(hw_start),
		.en(st_q == ST_HWRST),
		.lim(rr_lim),
		.hit(rr_hit)
	);
	fsrl_cnt u_rcmd (
		.clk(SYS_CLK),
		.rstn(RSTN),
		.clr(st_q != ST_RCMD),
		.en(1'b1),
		.lim(RC_LIM),
		.hit(rc_hit)
	);
	always_comb begin
		st_d = st_q;
		start_prog = 1'b0;
		start_erase = 1'b0;
		chip = 1'b0;
		sect_add = 1'b0;
		susp = 1'b0;
		resume = 1'b0;
		abort = 1'b0;
		if (hw_start) begin
			st_d = ST_HWRST;
			abort = running || (st_q == ST_WIN);
		end else begin
			case (st_q)
				ST_READ: begin
					if (c_prog) begin
						st_d = ST_PROG;
						start_prog = 1'b1;
					end else if (c_chip) begin
						st_d = ST_ERASE;
						start_erase = 1'b1;
						chip = 1'b1;
					end else if (c_sect) begin
						st_d = ST_WIN;
						sect_add = 1'b1;
					end else if (c_auto) begin
						st_d = ST_AUTOSEL;
					end
				end
				ST_AUTOSEL: begin
					if (c_reset) st_d = ST_RCMD;
				end
				ST_PROG: begin
					// Reset and all other commands ignored
					if (pl_hit) begin
						st_d = ST_FAIL;
						abort = 1'b1;
					end else if (OP_DONE) begin
						st_d = ST_READ;
					end
				end
				ST_WIN: begin
					if (c_one_sect || c_sect) begin
						sect_add = 1'b1;
					end else if (win_hit) begin
						st_d = ST_ERASE;
						start_erase = 1'b1;
					end
				end
				ST_ERASE: begin
					if (pl_hit) begin
						st_d = ST_FAIL;
						abort = 1'b1;
					end else if (OP_DONE) begin
						st_d = ST_READ;
					end else if (c_susp) begin
						st_d = ST_SUSPEND;
						susp = 1'b1;
					end
				end
				ST_SUSPEND: begin
					if (c_prog) begin
						st_d = ST_SPROG;
						start_prog = 1'b1;
					end else if (c_one_sect) begin
						st_d = ST_ERASE;
						resume = 1'b1;
					end else if (c_reset) begin
						st_d = ST_RCMD;
					end
				end
				ST_SPROG: begin
					if (pl_hit) begin
						st_d = ST_FAIL;
						abort = 1'b1;
					end else if (OP_DONE) begin
						st_d = ST_SUSPEND;
					end
				end
				ST_FAIL: begin
					if (c_reset) st_d = ST_RCMD;
				end
				ST_RCMD: begin
					if (rc_hit) st_d = rcmd_susp_q ? ST_SUSPEND : ST_READ;
				end
				ST_HWRST: begin
					if (rr_hit && HW_RESET_N) st_d = ST_READ;
				end
				default: st_d = ST_READ;
			endcase
		end
	end
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_q <= ST_READ;
		end else begin
			st_q <= st_d;
		end
	end

	// Busy level latched at hardware reset picks the recovery time
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			hr_busy_q <= 1'b0;
		end else if (hw_start) begin
			hr_busy_q <= READY_BUSY_N_N_OE;
		end
	end

	// Where a failed or reset operation returns to
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			fail_susp_q <= 1'b0;
			fail_erase_q <= 1'b0;
			rcmd_susp_q <= 1'b0;
		end else begin
			if (st_d == ST_FAIL && st_q != ST_FAIL) begin
				fail_susp_q <= (st_q == ST_SPROG);
				fail_erase_q <= (st_q == ST_ERASE);
			end
			if (st_d == ST_RCMD && st_q != ST_RCMD) begin
				rcmd_susp_q <= (st_q == ST_SUSPEND) ||
					(st_q == ST_FAIL && fail_susp_q);
			end
		end
	end
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			prog_bit_q <= 1'b0;
		end else if (start_prog) begin
			prog_bit_q <= DIN[DQ_POLL];
		end
	end

	// Toggle bits advance only on status reads
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			t1_q <= 1'b0;
			t2_q <= 1'b0;
		end else if (RD_STROBE) begin
			if (running || st_q == ST_WIN || st_q == ST_FAIL) begin
				t1_q <= ~t1_q;
			end
			if (RD_IN_ERASE && (st_q == ST_ERASE || st_q == ST_WIN ||
				st_q == ST_SUSPEND)) begin
				t2_q <= ~t2_q;
			end
		end
	end
	always_comb begin
		dq_d = 8'h00;
		case (st_q)
			ST_PROG, ST_SPROG: begin
				dq_d[DQ_POLL] = ~prog_bit_q;
				dq_d[DQ_TGL1] = ~t1_q;
			end
			ST_WIN: begin
				dq_d[DQ_TGL1] = ~t1_q;
				dq_d[DQ_TIMER] = 1'b0;
				dq_d[DQ_TGL2] = RD_IN_ERASE ? ~t2_q : t2_q;
			end
			ST_ERASE: begin
				dq_d[DQ_TGL1] = ~t1_q;
				dq_d[DQ_TIMER] = 1'b1;
				dq_d[DQ_TGL2] = RD_IN_ERASE ? ~t2_q : t2_q;
			end
			ST_FAIL: begin
				dq_d[DQ_POLL] = fail_erase_q ? 1'b0 : ~prog_bit_q;
				dq_d[DQ_TGL1] = ~t1_q;
				dq_d[DQ_LIMIT] = 1'b1;
				dq_d[DQ_TIMER] = fail_erase_q;
			end
			ST_SUSPEND: begin
				if (RD_IN_ERASE) begin
					dq_d[DQ_POLL] = 1'b1;
					dq_d[DQ_TGL1] = t1_q;
					dq_d[DQ_TGL2] = ~t2_q;
				end else begin
					dq_d = ARRAY_DATA;
				end
			end
			default: dq_d = ARRAY_DATA;
		endcase
	end
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			DQ_OUT <= 8'h00;
		end else if (RD_STROBE) begin
			DQ_OUT <= dq_d;
		end
	end

	// Open drain: pin only ever pulled low
	assign rb_oe_d = (st_d == ST_PROG) || (st_d == ST_WIN) ||
		(st_d == ST_ERASE) || (st_d == ST_SPROG) || (st_d == ST_FAIL) ||
		(st_d == ST_HWRST && (hw_start ? READY_BUSY_N_N_OE : hr_busy_q));
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			READY_BUSY_N_N_O <= 1'b0;
			READY_BUSY_N_N_OE <= 1'b0;
		end else begin
			READY_BUSY_N_N_O <= 1'b0;
			READY_BUSY_N_N_OE <= rb_oe_d;
		end
	end
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			OP_START_PROG <= 1'b0;
			OP_START_ERASE <= 1'b0;
			OP_CHIP <= 1'b0;
			OP_SECT_ADD <= 1'b0;
			OP_SUSPEND <= 1'b0;
			OP_RESUME <= 1'b0;
			OP_ABORT <= 1'b0;
			MODE_AUTOSEL <= 1'b0;
		end else begin
			OP_START_PROG <= start_prog;
			OP_START_ERASE <= start_erase;
			OP_CHIP <= chip;
			OP_SECT_ADD <= sect_add;
			OP_SUSPEND <= susp;
			OP_RESUME <= resume;
			OP_ABORT <= abort;
			MODE_AUTOSEL <= (st_d == ST_AUTOSEL);
		end
	end
endmodule
`default_nettype wire

// File: fsrl_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fsrl_top_chk import fsrl_pkg::*; #(
	parameter int unsigned ERASE_WIN_CYC = ERASE_WIN_CYC_D
)(
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic HW_RESET_N,
	input wire logic READY_BUSY_N_N_O,
	input wire logic READY_BUSY_N_N_OE,
	input wire logic OP_START_PROG,
	input wire logic OP_START_ERASE,
	input wire logic OP_CHIP,
	input wire logic OP_SECT_ADD,
	input wire logic OP_SUSPEND,
	input wire logic OP_ABORT,
	input wire logic MODE_AUTOSEL
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	// Age of the newest sector command, saturating
	logic [15:0] age_q;
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			age_q <= 16'h0000;
		end else if (OP_SECT_ADD) begin
			age_q <= 16'h0000;
		end else if (age_q != 16'hffff) begin
			age_q <= age_q + 16'h0001;
		end
	end
	pin_drive_a: assert property (!READY_BUSY_N_N_O)
		else $error("ready pin drive value not low");
	prog_busy_a: assert property (
		OP_START_PROG |-> ##[0:1] READY_BUSY_N_N_OE)
		else $error("program start without busy");
	sect_busy_a: assert property (
		OP_SECT_ADD |-> ##1 READY_BUSY_N_N_OE)
		else $error("sector command without busy");
	win_len_a: assert property (
		OP_START_ERASE && !OP_CHIP |-> int'(age_q) + 2 >= ERASE_WIN_CYC
		&& int'(age_q) <= ERASE_WIN_CYC + 2)
		else $error("erase window length wrong");
	chip_pair_a: assert property (
		OP_CHIP |-> OP_START_ERASE && READY_BUSY_N_N_OE)
		else $error("chip erase start malformed");
	susp_ready_a: assert property (
		OP_SUSPEND |-> ##1 !READY_BUSY_N_N_OE)
		else $error("suspend left ready pin low");
	abort_busy_a: assert property (
		OP_ABORT |-> READY_BUSY_N_N_OE)
		else $error("abort without busy");
	hw_hold_a: assert property (
		!HW_RESET_N |=> $stable(READY_BUSY_N_N_OE))
		else $error("ready pin moved during hardware reset");
	autosel_ready_a: assert property (
		MODE_AUTOSEL |-> !READY_BUSY_N_N_OE)
		else $error("busy while in autoselect");
	cover property (OP_ABORT);
	cover property (OP_SUSPEND);
	cover property (OP_START_ERASE && !OP_CHIP);
endmodule
bind fsrl_top fsrl_top_chk #(.ERASE_WIN_CYC(ERASE_WIN_CYC)) u_chk (
	.SYS_CLK(SYS_CLK), .RSTN(RSTN), .HW_RESET_N(HW_RESET_N),
	.READY_BUSY_N_N_O(READY_BUSY_N_N_O), .READY_BUSY_N_N_OE(READY_BUSY_N_N_OE),
	.OP_START_PROG(OP_START_PROG), .OP_START_ERASE(OP_START_ERASE),
	.OP_CHIP(OP_CHIP), .OP_SECT_ADD(OP_SECT_ADD),
	.OP_SUSPEND(OP_SUSPEND), .OP_ABORT(OP_ABORT),
	.MODE_AUTOSEL(MODE_AUTOSEL));
`default_nettype wire

// File: fsrl_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module fsrl_top_test;
	import fsrl_pkg::*;
	localparam int PL = 8;
	typedef struct {
		logic [7:0] m;
		logic [7:0] v;
		logic [7:0] t;
		logic [7:0] s;
	} fsrl_note_t;
	fsrl_note_t notes[$];
	logic SYS_CLK = 1'b0;
	logic RSTN, HW_RESET_N, RD_IN_ERASE, PULSE_TICK, OP_DONE;
	logic WE_N, RD_STROBE, READY_BUSY_N_N_O, READY_BUSY_N_N_OE, OP_START_PROG, OP_CHIP;
	logic OP_START_ERASE, OP_SECT_ADD, OP_SUSPEND, OP_RESUME, OP_ABORT;
	logic MODE_AUTOSEL, rd_seen;
	logic [7:0] DIN, ARRAY_DATA, DQ_OUT, last_dq, d;
	logic [31:0] seed;
	int err_count, n_compared, n_prog, n_erase, n_sect, c, i;
	fsrl_top #(.ERASE_WIN_CYC(20), .READY_BUSY_CYC(30),
		.READY_IDLE_CYC(10), .PULSE_LIMIT(PL)) u_fsrl_top (
		.SYS_CLK(SYS_CLK), .RSTN(RSTN), .HW_RESET_N(HW_RESET_N),
		.WE_N(WE_N), .DIN(DIN), .RD_STROBE(RD_STROBE),
		.RD_IN_ERASE(RD_IN_ERASE), .ARRAY_DATA(ARRAY_DATA),
		.PULSE_TICK(PULSE_TICK), .OP_DONE(OP_DONE), .DQ_OUT(DQ_OUT),
		.READY_BUSY_N_N_O(READY_BUSY_N_N_O), .READY_BUSY_N_N_OE(READY_BUSY_N_N_OE),
		.OP_START_PROG(OP_START_PROG), .OP_START_ERASE(OP_START_ERASE),
		.OP_CHIP(OP_CHIP), .OP_SECT_ADD(OP_SECT_ADD),
		.OP_SUSPEND(OP_SUSPEND), .OP_RESUME(OP_RESUME),
		.OP_ABORT(OP_ABORT), .MODE_AUTOSEL(MODE_AUTOSEL));
	fsrl_host u_fsrl_host (.clk(SYS_CLK), .we_n(WE_N), .din(DIN),
		.rd_strobe(RD_STROBE));
	always #5 SYS_CLK = ~SYS_CLK;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [7:0] e, g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic flag(input string nm, input logic e, g);
		cmp(nm, {7'h00, e}, {7'h00, g});
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge SYS_CLK);
	endtask
	task automatic rd(input logic [7:0] m, v, t, s);
		notes.push_back('{m, v, t, s});
		u_fsrl_host.rd();
	endtask
	task automatic wr(input logic [7:0] b);
		u_fsrl_host.wr(b);
		// Reset command needs its recovery before new writes
		if (b == CMD_RESET) tick(25);
	endtask
	task automatic unlk(input logic [7:0] b);
		wr(CMD_UNLK1);
		wr(CMD_UNLK2);
		wr(b);
	endtask
	task automatic pulse(ref logic s);
		@(negedge SYS_CLK);
		s = 1'b1;
		@(negedge SYS_CLK);
		s = 1'b0;
	endtask
	task automatic wait_oe(input logic v, input int lim);
		for (c = 0; READY_BUSY_N_N_OE !== v; c++) begin
			if (c == lim) begin
				flag("ready_wait", v, READY_BUSY_N_N_OE);
				end_sim();
			end
			tick(1);
		end
	endtask
	always @(posedge SYS_CLK) begin
		rd_seen <= RD_STROBE;
		n_prog += int'(OP_START_PROG === 1'b1);
		n_erase += int'(OP_START_ERASE === 1'b1);
		n_sect += int'(OP_SECT_ADD === 1'b1);
	end
	// Read data settles on the edge that samples the strobe
	always @(negedge SYS_CLK) begin
		if (rd_seen === 1'b1 && notes.size() > 0) begin
			cmp("dq_value", notes[0].v, DQ_OUT & notes[0].m);
			cmp("dq_toggle", notes[0].t, (DQ_OUT ^ last_dq) & notes[0].t);
			cmp("dq_static", 8'h00, (DQ_OUT ^ last_dq) & notes[0].s);
			void'(notes.pop_front());
			last_dq = DQ_OUT;
		end
	end
	initial begin
		RSTN = 1'b0;
		HW_RESET_N = 1'b1;
		RD_IN_ERASE = 1'b0;
		PULSE_TICK = 1'b0;
		OP_DONE = 1'b0;
		seed = lfsr(32'h8b07);
		ARRAY_DATA = seed[15:8];
		d = seed[7:0];
		tick(4);
		RSTN = 1'b1;
		tick(1);
		flag("ready_busy", 1'b0, READY_BUSY_N_N_OE);
		rd(8'hff, ARRAY_DATA, 8'h00, 8'h00);
		unlk(CMD_PROG);
		wr(d);
		tick(1);
		flag("ready_busy", 1'b1, READY_BUSY_N_N_OE);
		rd(8'ha0, {~d[7], 7'h00}, 8'h00, 8'h00);
		rd(8'h00, 8'h00, 8'h40, 8'h00);
		wr(CMD_RESET);
		flag("ready_busy", 1'b1, READY_BUSY_N_N_OE);
		pulse(OP_DONE);
		ARRAY_DATA = d;
		tick(1);
		flag("ready_busy", 1'b0, READY_BUSY_N_N_OE);
		rd(8'hff, d, 8'h00, 8'h00);
		rd(8'hff, d, 8'h00, 8'h40);
		$display("test program done");
		unlk(CMD_PROG);
		wr(d);
		for (i = 1; i < PL; i++) pulse(PULSE_TICK);
		rd(8'h20, 8'h00, 8'h00, 8'h00);
		pulse(PULSE_TICK);
		tick(1);
		rd(8'h20, 8'h20, 8'h40, 8'h00);
		flag("ready_busy", 1'b1, READY_BUSY_N_N_OE);
		u_fsrl_host.wr(CMD_RESET);
		wait_oe(1'b0, 23);
		rd(8'hff, d, 8'h00, 8'h00);
		$display("test limit done");
		unlk(CMD_RESET);
		wr(CMD_PROG);
		wr(d);
		unlk(CMD_ERASE);
		unlk(CMD_RESET);
		wr(CMD_SECT);
		cmp("prog_starts", 8'h02, 8'(n_prog));
		cmp("sector_adds", 8'h00, 8'(n_sect));
		unlk(CMD_AUTO);
		unlk(CMD_PROG);
		wr(d);
		flag("autosel", 1'b1, MODE_AUTOSEL);
		wr(CMD_RESET);
		flag("autosel", 1'b0, MODE_AUTOSEL);
		$display("test abort done");
		RD_IN_ERASE = 1'b1;
		unlk(CMD_ERASE);
		unlk(CMD_SECT);
		tick(1);
		flag("ready_busy", 1'b1, READY_BUSY_N_N_OE);
		rd(8'h08, 8'h00, 8'h00, 8'h00);
		tick(6);
		wr(CMD_SECT);
		tick(12);
		rd(8'h08, 8'h00, 8'h00, 8'h00);
		for (i = 0; i < 30 && n_erase == 0; i++) tick(1);
		cmp("erase_starts", 8'h01, 8'(n_erase));
		rd(8'ha8, 8'h08, 8'h00, 8'h00);
		rd(8'h00, 8'h00, 8'h44, 8'h00);
		unlk(CMD_PROG);
		wr(d);
		wr(CMD_SECT);
		wr(CMD_RESET);
		flag("ready_busy", 1'b1, READY_BUSY_N_N_OE);
		cmp("prog_starts", 8'h02, 8'(n_prog));
		cmp("sector_adds", 8'h02, 8'(n_sect));
		wr(CMD_SUSP);
		flag("ready_busy", 1'b0, READY_BUSY_N_N_OE);
		rd(8'ha0, 8'h80, 8'h00, 8'h00);
		rd(8'h00, 8'h00, 8'h04, 8'h40);
		RD_IN_ERASE = 1'b0;
		ARRAY_DATA = seed[23:16];
		rd(8'hff, seed[23:16], 8'h00, 8'h00);
		RD_IN_ERASE = 1'b1;
		unlk(CMD_PROG);
		wr(CMD_RESET);
		rd(8'ha0, 8'h80, 8'h00, 8'h00);
		unlk(CMD_PROG);
		wr(d);
		tick(1);
		flag("ready_busy", 1'b1, READY_BUSY_N_N_OE);
		rd(8'ha0, {~d[7], 7'h00}, 8'h00, 8'h00);
		pulse(OP_DONE);
		wait_oe(1'b0, 2);
		wr(CMD_SECT);
		flag("ready_busy", 1'b1, READY_BUSY_N_N_OE);
		pulse(OP_DONE);
		wait_oe(1'b0, 2);
		unlk(CMD_ERASE);
		unlk(CMD_CHIP);
		tick(1);
		cmp("erase_starts", 8'h02, 8'(n_erase));
		rd(8'h08, 8'h08, 8'h00, 8'h00);
		pulse(OP_DONE);
		wait_oe(1'b0, 2);
		$display("test erase done");
		unlk(CMD_PROG);
		wr(d);
		HW_RESET_N = 1'b0;
		tick(3);
		HW_RESET_N = 1'b1;
		wait_oe(1'b0, 40);
		flag("busy_hold", 1'b1, c >= 24 && c <= 30);
		HW_RESET_N = 1'b0;
		tick(2);
		flag("ready_busy", 1'b0, READY_BUSY_N_N_OE);
		HW_RESET_N = 1'b1;
		tick(14);
		rd(8'hff, seed[23:16], 8'h00, 8'h00);
		tick(2);
		$display("test hardware reset done");
		end_sim();
	end
endmodule
`default_nettype wire
